// ---- pkg/cfglk_pkg.sv ----
package cfglk_pkg;

   // ---------------------------------------------------------------
   // option byte layout
   // ---------------------------------------------------------------
   localparam int unsigned OPT_W = 8;
   localparam int unsigned XD_ADDR_W = 16;
   localparam int unsigned AREA_W = 3;
   localparam int unsigned WDT_CLK_BIT = 7;
   localparam int unsigned RST_PIN_DIS_BIT = 6;
   localparam int unsigned PORT_RST_LVL_BIT = 5;
   localparam int unsigned BOD_LVL_BIT = 4;
   localparam int unsigned RSVD_HI_BIT = 3;
   localparam int unsigned RSVD_LO_BIT = 2;
   localparam int unsigned OSC_SEL_HI_BIT = 1;
   localparam int unsigned OSC_SEL_LO_BIT = 0;
   localparam int unsigned CODE_LOCK_BIT = 7;
   localparam int unsigned DATA_LOCK_BIT = 6;

   // erased flash reads as all ones, so this is the value before load
   localparam logic [7:0] OPT_RESET = 8'hff;
   localparam logic [7:0] LOCK_RESET = 8'hff;

   // external-data addresses of the two option bytes
   localparam logic [15:0] OPT_PRIMARY_ADDR = 16'hfff0;
   localparam logic [15:0] SECURITY_LOCK_ADDR = 16'hfff1;

   // nonvolatile fetch select codes
   localparam logic NV_SEL_PRIMARY = 1'b0;
   localparam logic NV_SEL_LOCK = 1'b1;

   // tool area mask bits; several may be set together
   localparam int unsigned AREA_CODE_BIT = 0;
   localparam int unsigned AREA_DATA_BIT = 1;
   localparam int unsigned AREA_CFG_BIT = 2;
   localparam logic [2:0] AREA_ALL = 3'h7;

   // ---------------------------------------------------------------
   // enumerations
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      OSC_CRYSTAL = 2'h0,
      OSC_INT_RC = 2'h1,
      OSC_RSVD = 2'h2,
      OSC_EXT_CLK = 2'h3
   } cfglk_osc_t;

   typedef enum logic [1:0] {
      OP_READ = 2'h0,
      OP_PROG = 2'h1,
      OP_ERASE = 2'h2,
      OP_BAD = 2'h3
   } cfglk_op_t;

   // gray order along the load path
   typedef enum logic [1:0] {
      ST_WAIT = 2'h0,
      ST_LOAD1 = 2'h1,
      ST_LOAD2 = 2'h3,
      ST_RUN = 2'h2
   } cfglk_state_t;

endpackage

// ---- pkg/cfglk_lock_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface cfglk_lock_if;
   import cfglk_pkg::*;
   logic loaded;
   logic [7:0] lock_byte;
   logic req;
   cfglk_op_t op;
   logic [AREA_W-1:0] area;
   logic grant;
   logic deny;
   logic lock_invalid;
   modport ctrl(output loaded, lock_byte, req, op, area,
                input grant, deny, lock_invalid);
   modport gate(input loaded, lock_byte, req, op, area,
                output grant, deny, lock_invalid);
endinterface
`default_nettype wire

// ---- verilog/cfglk_access.sv ----
`timescale 1ns/1ps
`default_nettype none
module cfglk_access
   import cfglk_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   cfglk_lock_if.gate lk
);

   // ---------------------------------------------------------------
   // lock decode
   // ---------------------------------------------------------------
   wire code_bit = lk.lock_byte[CODE_LOCK_BIT];
   wire data_bit = lk.lock_byte[DATA_LOCK_BIT];
   wire combo_bad = code_bit & ~data_bit;
   // the unsupported code is treated as fully locked, the safe side
   wire code_open = code_bit & ~combo_bad;
   wire data_open = data_bit & ~combo_bad;
   // option bytes are shut as soon as either lock is set
   wire cfg_open = code_open & data_open;
   wire area_ok = (~lk.area[AREA_CODE_BIT] | code_open) &
                  (~lk.area[AREA_DATA_BIT] | data_open) &
                  (~lk.area[AREA_CFG_BIT] | cfg_open);
   // a whole-chip erase stays legal so a locked part can be reused
   wire chip_erase = (lk.op == OP_ERASE) && (lk.area == AREA_ALL);
   wire op_ok = (lk.op != OP_BAD) && (lk.area != '0);
   wire next_grant = lk.req & lk.loaded & op_ok & (area_ok | chip_erase);
   wire next_deny = lk.req & ~next_grant;

   // ---------------------------------------------------------------
   // registered answer, one cycle after the request
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         lk.grant <= 1'b0;
         lk.deny <= 1'b0;
         lk.lock_invalid <= 1'b0;
      end else if (i_ce) begin
         lk.grant <= next_grant;
         lk.deny <= next_deny;
         lk.lock_invalid <= lk.loaded & combo_bad;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   code_read_block_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      i_ce && lk.req && lk.loaded && !code_bit && lk.op == OP_READ &&
      lk.area[AREA_CODE_BIT] |=> lk.deny && !lk.grant)
      else $error("code area read granted while code locked");

   data_read_block_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      i_ce && lk.req && lk.loaded && !data_bit && lk.op != OP_ERASE &&
      lk.area[AREA_DATA_BIT] |=> lk.deny)
      else $error("data area access granted while data locked");

   open_access_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      i_ce && lk.req && lk.loaded && code_bit && data_bit &&
      lk.op != OP_BAD && lk.area != '0 |=> lk.grant)
      else $error("unlocked access refused");

   bad_combo_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      i_ce && lk.req && lk.loaded && combo_bad && lk.op == OP_READ
      |=> lk.deny)
      else $error("unsupported lock combination let a read through");

   cov_locked_read: cover property (@(posedge i_clk)
      lk.req && !code_bit && lk.op == OP_READ ##1 lk.deny);
   cov_chip_erase: cover property (@(posedge i_clk)
      lk.req && !code_bit && chip_erase ##1 lk.grant);

endmodule
`default_nettype wire

// ---- verilog/cfglk_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module cfglk_top
   import cfglk_pkg::*;
#(
   parameter int unsigned NPINS = 8
)(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   output logic o_nv_rd,
   output logic o_nv_sel,
   input wire logic i_nv_ack,
   input wire logic [OPT_W-1:0] i_nv_data,
   output logic o_cfg_loaded,
   output logic o_watchdog_clock_select,
   output logic o_reset_pin_disable,
   output logic o_port_reset_level,
   output logic o_brownout_level_select,
   output logic o_osc_source_sel_hi,
   output logic o_osc_source_sel_lo,
   output logic o_osc_sel_reserved,
   input wire logic i_xd_rd,
   input wire logic [XD_ADDR_W-1:0] i_xd_addr,
   output logic [OPT_W-1:0] o_xd_rdata,
   output logic o_xd_hit,
   input wire logic i_tool_req,
   input wire logic [1:0] i_tool_op,
   input wire logic [AREA_W-1:0] i_tool_area,
   output logic o_tool_grant,
   output logic o_tool_deny,
   output logic o_lock_invalid,
   output logic o_code_area_lock,
   output logic o_data_area_lock,
   input wire logic i_in_circuit_programming,
   output logic o_pin_quasi,
   output logic [NPINS-1:0] o_port_latch_init
);

   // ---------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------
   if (NPINS < 1 || NPINS > 64) begin : g_bad_npins
      $error("NPINS must lie between 1 and 64");
   end

   // ---------------------------------------------------------------
   // state and storage
   // ---------------------------------------------------------------
   cfglk_state_t state;
   cfglk_state_t next_state;
   logic [OPT_W-1:0] opt_primary;
   logic [OPT_W-1:0] opt_lock;
   logic icp_q;

   cfglk_lock_if lk();

   // ---------------------------------------------------------------
   // load sequencer
   // ---------------------------------------------------------------
   // one fetch per byte; the run state has no way back, so only an
   // i_rst reset can reload the settings
   wire ack_primary = (state == ST_LOAD1) && i_nv_ack;
   wire ack_lock = (state == ST_LOAD2) && i_nv_ack;

   always_comb begin
      next_state = state;
      unique case (state)
         ST_WAIT: next_state = ST_LOAD1;
         ST_LOAD1: begin
            if (i_nv_ack) begin
               next_state = ST_LOAD2;
            end
         end
         ST_LOAD2: begin
            if (i_nv_ack) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: next_state = ST_RUN;
      endcase
   end

   // fetch strobes: pulse in the cycle a byte is first asked for
   wire next_nv_rd = (state == ST_WAIT) || ack_primary;
   wire next_nv_sel = ack_primary ? NV_SEL_LOCK :
                      (state == ST_LOAD2) ? NV_SEL_LOCK : NV_SEL_PRIMARY;

   // sequencer and fetch port
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state <= ST_WAIT;
         o_nv_rd <= 1'b0;
         o_nv_sel <= NV_SEL_PRIMARY;
      end else if (i_ce) begin
         state <= next_state;
         o_nv_rd <= next_nv_rd;
         o_nv_sel <= next_nv_sel;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         opt_primary <= OPT_RESET;
         opt_lock <= LOCK_RESET;
      end else if (i_ce) begin
         if (ack_primary) begin
            opt_primary <= i_nv_data;
         end
         if (ack_lock) begin
            opt_lock <= i_nv_data;
         end
      end
   end

   // ---------------------------------------------------------------
   // setting decode
   // ---------------------------------------------------------------
   // watchdog clock
   wire dec_wdt = opt_primary[WDT_CLK_BIT];
   wire dec_rst_dis = opt_primary[RST_PIN_DIS_BIT];
   wire dec_port_lvl = opt_primary[PORT_RST_LVL_BIT];
   // brownout level, 1 picks the lower threshold
   wire dec_bod = opt_primary[BOD_LVL_BIT];
   // oscillator selector, hi bit on top
   wire [1:0] dec_osc = {opt_primary[OSC_SEL_HI_BIT],
                         opt_primary[OSC_SEL_LO_BIT]};
   // the reserved code is flagged; the clock unit falls back
   wire dec_osc_rsvd = (cfglk_osc_t'(dec_osc) == OSC_RSVD);
   // bits RSVD_HI_BIT and RSVD_LO_BIT feed no setting output; only the cpu read sees them

   // decoded settings are registered so outputs are plain flops
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_watchdog_clock_select <= OPT_RESET[WDT_CLK_BIT];
         o_reset_pin_disable <= OPT_RESET[RST_PIN_DIS_BIT];
         o_port_reset_level <= OPT_RESET[PORT_RST_LVL_BIT];
         o_brownout_level_select <= OPT_RESET[BOD_LVL_BIT];
         o_osc_source_sel_hi <= OPT_RESET[OSC_SEL_HI_BIT];
         o_osc_source_sel_lo <= OPT_RESET[OSC_SEL_LO_BIT];
         o_osc_sel_reserved <= 1'b0;
         o_code_area_lock <= 1'b0;
         o_data_area_lock <= 1'b0;
         o_cfg_loaded <= 1'b0;
      end else if (i_ce) begin
         o_watchdog_clock_select <= dec_wdt;
         o_reset_pin_disable <= dec_rst_dis;
         o_port_reset_level <= dec_port_lvl;
         o_brownout_level_select <= dec_bod;
         o_osc_source_sel_hi <= dec_osc[1];
         o_osc_source_sel_lo <= dec_osc[0];
         o_osc_sel_reserved <= dec_osc_rsvd;
         // lock outputs read high while a region's raw lock bit is clear
         o_code_area_lock <= ~opt_lock[CODE_LOCK_BIT];
         o_data_area_lock <= ~opt_lock[DATA_LOCK_BIT];
         o_cfg_loaded <= (state == ST_RUN);
      end
   end

   // ---------------------------------------------------------------
   // processor read of the option bytes
   // ---------------------------------------------------------------
   // address decode
   wire hit_primary = i_xd_rd && (i_xd_addr == OPT_PRIMARY_ADDR);
   wire hit_lock = i_xd_rd && (i_xd_addr == SECURITY_LOCK_ADDR);
   wire [OPT_W-1:0] xd_sel = hit_primary ? opt_primary :
                             hit_lock ? opt_lock : '0;

   // the cpu path ignores the locks: they only gate the tool port
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_xd_rdata <= '0;
         o_xd_hit <= 1'b0;
      end else if (i_ce) begin
         o_xd_rdata <= xd_sel;
         o_xd_hit <= hit_primary | hit_lock;
      end
   end

   // ---------------------------------------------------------------
   // tool access gate
   // ---------------------------------------------------------------
   // area mask lets code and data go singly or together
   assign lk.loaded = (state == ST_RUN);
   assign lk.lock_byte = opt_lock;
   assign lk.req = i_tool_req;
   assign lk.op = cfglk_op_t'(i_tool_op);
   assign lk.area = i_tool_area;

   cfglk_access u_access (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .lk(lk.gate)
   );

   assign o_tool_grant = lk.grant;
   assign o_tool_deny = lk.deny;
   assign o_lock_invalid = lk.lock_invalid;

   // ---------------------------------------------------------------
   // pin state on programming entry
   // ---------------------------------------------------------------
   // quasi mode, all high
   wire [NPINS-1:0] next_latch = i_in_circuit_programming ? '1 :
                                 {NPINS{dec_port_lvl}};

   // latch init follows the level bit but is overridden while the
   // tool holds the part, so no pin fights the programming lines
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         icp_q <= 1'b0;
         o_pin_quasi <= 1'b0;
         o_port_latch_init <= {NPINS{OPT_RESET[PORT_RST_LVL_BIT]}};
      end else if (i_ce) begin
         icp_q <= i_in_circuit_programming;
         o_pin_quasi <= i_in_circuit_programming;
         o_port_latch_init <= next_latch;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   settings_frozen_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      state == ST_RUN |=> $stable(opt_primary) && $stable(opt_lock))
      else $error("option bytes changed during run");

   load_order_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      i_ce && ack_lock |=> state == ST_RUN && opt_lock == $past(i_nv_data))
      else $error("lock byte not captured on its ack");

   xd_read_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      i_ce && hit_primary |=> o_xd_hit && o_xd_rdata == $past(opt_primary))
      else $error("primary option byte read wrong");

   wdt_decode_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      i_ce |=> o_watchdog_clock_select == $past(opt_primary[WDT_CLK_BIT]))
      else $error("watchdog clock select mismatch");

   osc_decode_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      i_ce && opt_primary[1:0] == 2'h2 |=> o_osc_sel_reserved &&
      o_osc_source_sel_hi && !o_osc_source_sel_lo)
      else $error("reserved oscillator code not flagged");

   icp_pins_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      i_ce && i_in_circuit_programming |=> o_pin_quasi &&
      o_port_latch_init == {NPINS{1'b1}})
      else $error("pins not quasi high on programming entry");

   port_level_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      i_ce && !i_in_circuit_programming && !dec_port_lvl
      |=> o_port_latch_init == '0)
      else $error("port latch init ignores reset level bit");

   rst_pin_decode_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      i_ce |=> o_reset_pin_disable == $past(opt_primary[RST_PIN_DIS_BIT]))
      else $error("reset pin disable mismatch");

   port_lvl_decode_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      i_ce |=> o_port_reset_level == $past(opt_primary[PORT_RST_LVL_BIT]))
      else $error("port reset level mismatch");

   bod_decode_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      i_ce |=> o_brownout_level_select == $past(opt_primary[BOD_LVL_BIT]))
      else $error("brownout level select mismatch");

   osc_bits_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      i_ce |=> o_osc_source_sel_hi == $past(opt_primary[1]) &&
      o_osc_source_sel_lo == $past(opt_primary[0]))
      else $error("oscillator select bits mismatch");

   code_lock_out_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      i_ce |=> o_code_area_lock == !$past(opt_lock[CODE_LOCK_BIT]))
      else $error("code area lock output mismatch");

   data_lock_out_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      i_ce |=> o_data_area_lock == !$past(opt_lock[DATA_LOCK_BIT]))
      else $error("data area lock output mismatch");

   lock_invalid_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      i_ce && state == ST_RUN |=>
      o_lock_invalid == (opt_lock[7] && !opt_lock[6]))
      else $error("unsupported lock code not flagged");

   fetch_pulse_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      i_ce && o_nv_rd |=> !o_nv_rd)
      else $error("fetch request longer than one cycle");

   run_no_fetch_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      state == ST_RUN |=> state == ST_RUN && !o_nv_rd)
      else $error("option bytes fetched again during run");

   loaded_flag_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      i_ce |=> o_cfg_loaded == ($past(state) == ST_RUN))
      else $error("loaded flag out of step with sequencer");

   ce_freeze_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      !i_ce |=> $stable(state) && $stable(o_pin_quasi) &&
      $stable(o_port_latch_init))
      else $error("state moved while clock enable low");

   xd_lock_read_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      i_ce && hit_lock |=> o_xd_hit && o_xd_rdata == $past(opt_lock))
      else $error("lock byte read wrong");

   xd_miss_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      i_ce && !hit_primary && !hit_lock |=> !o_xd_hit && o_xd_rdata == '0)
      else $error("option byte hit on a foreign address");

   cov_load_done: cover property (@(posedge i_clk)
      state == ST_LOAD2 && i_nv_ack ##1 state == ST_RUN);
   cov_icp_entry: cover property (@(posedge i_clk)
      !icp_q && i_in_circuit_programming ##1 o_pin_quasi);
   cov_xd_lock: cover property (@(posedge i_clk) hit_lock ##1 o_xd_hit);

endmodule
`default_nettype wire

// ---- verification/cfglk_nv_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cfglk_nv_model
   import cfglk_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rd,
   input wire logic i_sel,
   input wire logic [OPT_W-1:0] i_primary,
   input wire logic [OPT_W-1:0] i_lock,
   input wire logic [3:0] i_delay,
   output logic o_ack,
   output logic [OPT_W-1:0] o_data
);
   // ---------------------------------------------------------------
   // option byte store
   // ---------------------------------------------------------------
   logic pend = 1'b0;
   logic psel = 1'b0;
   logic [3:0] cnt = 4'h0;
   initial o_ack = 1'b0;
   initial o_data = 8'h00;

   // a fetch waits i_delay cycles; outside the answer the data lines
   // toggle so a stale byte never passes for a fresh one
   // one byte per fetch
   always @(posedge i_clk) begin
      o_ack <= 1'b0;
      o_data <= ~o_data;
      if (i_rd && i_delay == 4'h0) begin
         o_ack <= 1'b1;
         o_data <= i_sel ? i_lock : i_primary;
      end else if (i_rd) begin
         pend <= 1'b1;
         psel <= i_sel;
         cnt <= i_delay - 4'h1;
      end else if (pend && cnt == 4'h0) begin
         pend <= 1'b0;
         o_ack <= 1'b1;
         o_data <= psel ? i_lock : i_primary;
      end else if (pend) begin
         cnt <= cnt - 4'h1;
      end
   end
endmodule
`default_nettype wire

// ---- verification/test_config_byte_and_lock_logic.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
   total_checks++; \
   if ((g) !== (e)) begin \
      n_fail++; \
      $display("[ERR] %s expected %h seen %h", nm, e, g); \
   end \
end
module test_config_byte_and_lock_logic;
   import cfglk_pkg::*;
   localparam int NP = 8;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_ce = 1'b1;
   logic i_xd_rd = 1'b0;
   logic [15:0] i_xd_addr = 16'h0000;
   logic i_tool_req = 1'b0;
   logic [1:0] i_tool_op = 2'h0;
   logic [2:0] i_tool_area = 3'h0;
   logic i_icp = 1'b0;
   logic nv_rd, nv_sel, nv_ack, loaded, wdt, reset_pin_disable, prl, bod, oh, ol, ores;
   logic [7:0] nv_data, xd_rdata;
   logic xd_hit, gnt, dny, linv, clk_lk, dlk_lk, quasi;
   logic [NP-1:0] latch;
   logic [7:0] m_p = 8'hff;
   logic [7:0] m_l = 8'hff;
   logic [3:0] m_d = 4'h0;
   logic [7:0] p, l;
   logic [7:0] tp [4] = '{8'h00, 8'ha6, 8'h5d, 8'hc3};
   logic [7:0] tl [4] = '{8'hff, 8'h7f, 8'hbf, 8'h3f};
   logic [2:0] ar [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
   int n_fail = 0;
   int total_checks = 0;

   always #4 i_clk = ~i_clk;

   cfglk_top #(.NPINS(NP)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
      .o_nv_rd(nv_rd), .o_nv_sel(nv_sel), .i_nv_ack(nv_ack),
      .i_nv_data(nv_data), .o_cfg_loaded(loaded),
      .o_watchdog_clock_select(wdt), .o_reset_pin_disable(reset_pin_disable),
      .o_port_reset_level(prl), .o_brownout_level_select(bod),
      .o_osc_source_sel_hi(oh), .o_osc_source_sel_lo(ol),
      .o_osc_sel_reserved(ores), .i_xd_rd(i_xd_rd), .i_xd_addr(i_xd_addr),
      .o_xd_rdata(xd_rdata), .o_xd_hit(xd_hit), .i_tool_req(i_tool_req),
      .i_tool_op(i_tool_op), .i_tool_area(i_tool_area),
      .o_tool_grant(gnt), .o_tool_deny(dny), .o_lock_invalid(linv),
      .o_code_area_lock(clk_lk), .o_data_area_lock(dlk_lk),
      .i_in_circuit_programming(i_icp), .o_pin_quasi(quasi),
      .o_port_latch_init(latch));

   cfglk_nv_model nv (.i_clk(i_clk), .i_rd(nv_rd), .i_sel(nv_sel),
      .i_primary(m_p), .i_lock(m_l), .i_delay(m_d), .o_ack(nv_ack),
      .o_data(nv_data));

   // ---------------------------------------------------------------
   // access tasks
   // ---------------------------------------------------------------
   task automatic end_sim;
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // cpu external-data read, answer one edge after the request edge
   task automatic xd_read(input logic [15:0] a, input logic h,
                          input logic [7:0] d);
      @(posedge i_clk);
      i_xd_rd <= 1'b1;
      i_xd_addr <= a;
      @(posedge i_clk);
      i_xd_rd <= 1'b0;
      #1;
      `CHK("xd_hit", h, xd_hit)
      `CHK("xd_rdata", d, xd_rdata)
   endtask

   task automatic tool(input logic [1:0] op, input logic [2:0] a,
                       input logic g);
      @(posedge i_clk);
      i_tool_req <= 1'b1;
      i_tool_op <= op;
      i_tool_area <= a;
      @(posedge i_clk);
      i_tool_req <= 1'b0;
      #1;
      `CHK("tool_grant", g, gnt)
      `CHK("tool_deny", ~g, dny)
   endtask

   // lock 10 counts as both locked; whole-chip erase stays open
   function automatic logic exp_gnt(input logic [7:0] lk,
                                    input logic [1:0] op,
                                    input logic [2:0] a);
      logic cl;
      logic dl;
      cl = ~lk[7] | ~lk[6];
      dl = ~lk[6];
      if (op == 2'h3 || a == 3'h0) return 1'b0;
      if (op == 2'h2 && a == 3'h7) return 1'b1;
      return !((a[0] & cl) | (a[1] & dl) | (a[2] & cl));
   endfunction

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      repeat (5000) @(posedge i_clk);
      n_fail++;
      end_sim();
   end

   initial begin
      repeat (3) @(posedge i_clk);
      for (int k = 0; k < 4; k++) begin
         p = tp[k];
         l = tl[k];
         m_p <= p;
         m_l <= l;
         m_d <= 4'(k);
         @(posedge i_clk);
         i_rst <= 1'b1;
         repeat (3) @(posedge i_clk);
         #1;
         `CHK("rst_loaded", 1'b0, loaded)
         `CHK("rst_wdt", 1'b1, wdt)
         `CHK("rst_latch", {NP{1'b1}}, latch)
         @(posedge i_clk);
         i_rst <= 1'b0;
         tool(2'h0, 3'h1, 1'b0);
         for (int w = 0; w < 60 && loaded !== 1'b1; w++) @(posedge i_clk);
         #1;
         `CHK("loaded", 1'b1, loaded)
         `CHK("wdt", p[7], wdt)
         `CHK("rpd", p[6], reset_pin_disable)
         `CHK("port_lvl", p[5], prl)
         `CHK("latch", {NP{p[5]}}, latch)
         `CHK("bod", p[4], bod)
         `CHK("osc_hi", p[1], oh)
         `CHK("osc_lo", p[0], ol)
         `CHK("osc_rsvd", p[1:0] == 2'h2, ores)
         // the lock outputs show the raw bits; code 10 is flagged apart
         `CHK("code_lock", ~l[7], clk_lk)
         `CHK("data_lock", ~l[6], dlk_lk)
         `CHK("lock_inv", l[7:6] == 2'h2, linv)
         xd_read(OPT_PRIMARY_ADDR, 1'b1, p);
         xd_read(SECURITY_LOCK_ADDR, 1'b1, l);
         xd_read(16'hfff2, 1'b0, 8'h00);
         // every op against six of the eight area masks (not 5 or 6), one idle cycle between requests
         for (int o = 0; o < 4; o++) begin
            for (int a = 0; a < 6; a++) begin
               tool(2'(o), ar[a], exp_gnt(l, 2'(o), ar[a]));
            end
         end
         // erase then option programming, one idle cycle apart
         tool(2'h2, 3'h7, 1'b1);
         tool(2'h1, 3'h4, exp_gnt(l, 2'h1, 3'h4));
         // new stored bytes must not leak in before the next reset
         m_p <= ~p;
         m_l <= ~l;
         repeat (4) @(posedge i_clk);
         xd_read(OPT_PRIMARY_ADDR, 1'b1, p);
         #1;
         `CHK("frozen_wdt", p[7], wdt)
         @(posedge i_clk);
         i_icp <= 1'b1;
         @(posedge i_clk);
         #1;
         `CHK("icp_quasi", 1'b1, quasi)
         `CHK("icp_latch", {NP{1'b1}}, latch)
         @(posedge i_clk);
         i_icp <= 1'b0;
         @(posedge i_clk);
         #1;
         `CHK("run_quasi", 1'b0, quasi)
         `CHK("run_latch", {NP{p[5]}}, latch)
         // clock enable low must hold the pins through a mode change
         @(posedge i_clk);
         i_ce <= 1'b0;
         i_icp <= 1'b1;
         repeat (2) @(posedge i_clk);
         #1;
         `CHK("ce_freeze", 1'b0, quasi)
         @(posedge i_clk);
         i_ce <= 1'b1;
         i_icp <= 1'b0;
         $display("case %0d done", k);
      end
      end_sim();
   end
endmodule
`default_nettype wire
